/* verilog/bcsm_defs.svh */
// offsets, fixed field values and reset values of the bridge configuration space
// assumes byte offsets within a 4 KB configuration space, dword aligned
`ifndef BCSM_DEFS_SVH
`define BCSM_DEFS_SVH

// ----------------------------------------------------------------------
// standard header region, byte offsets
// ----------------------------------------------------------------------
`define BCSM_OFF_IDENT 8'h00
`define BCSM_OFF_CMD_STAT 8'h04
`define BCSM_OFF_REV_CLASS 8'h08
`define BCSM_OFF_LINE_HDR 8'h0C
`define BCSM_OFF_BUS_NUM 8'h18
`define BCSM_OFF_IO_WIN 8'h1C
`define BCSM_OFF_MEM_WIN 8'h20
`define BCSM_OFF_PF_WIN 8'h24
`define BCSM_OFF_PF_BASE_UP 8'h28
`define BCSM_OFF_PF_LIM_UP 8'h2C
`define BCSM_OFF_IO_UP 8'h30
`define BCSM_OFF_CAP_PTR 8'h34
`define BCSM_OFF_INT_BRIDGE 8'h3C
`define BCSM_OFF_PM_HDR 8'h80
`define BCSM_OFF_PM_DATA 8'h84
`define BCSM_OFF_MSI_HDR 8'h8C
`define BCSM_OFF_MSI_ADDR 8'h90
`define BCSM_OFF_MSI_UADDR 8'h94
`define BCSM_OFF_MSI_DATA 8'h98
`define BCSM_OFF_PD_HDR 8'h9C
`define BCSM_OFF_PD_WORD 8'hA0
`define BCSM_OFF_VEND_HDR 8'hA4
`define BCSM_OFF_CSR_A 8'hA8
`define BCSM_OFF_CSR_B 8'hAC
`define BCSM_OFF_ACK_REPLAY 8'hB0
`define BCSM_OFF_PHY_CTL0 8'hB4
`define BCSM_OFF_CSR_C 8'hB8
`define BCSM_OFF_PHY_CTL2 8'hBC
`define BCSM_OFF_LANE 8'hC0
`define BCSM_OFF_SUB_HDR 8'hC4
`define BCSM_OFF_SUB_IDENT 8'hC8
`define BCSM_OFF_PIN_IO 8'hD8
`define BCSM_OFF_PROM 8'hDC
`define BCSM_OFF_PCIE_HDR 8'hE0
`define BCSM_OFF_DEV_CAP 8'hE4
`define BCSM_OFF_DEV_CTL 8'hE8
`define BCSM_OFF_LINK_CAP 8'hEC
`define BCSM_OFF_LINK_CTL 8'hF0
`define BCSM_OFF_SLOT_CAP 8'hF4
`define BCSM_OFF_SLOT_CTL 8'hF8

// ----------------------------------------------------------------------
// fixed values: header type, capability chain, extended chain
// ----------------------------------------------------------------------
`define BCSM_HDR_TYPE_BRIDGE 8'h01
`define BCSM_CAP_PTR_FIRST 8'h80
`define BCSM_PM_LINK 16'h8C01
`define BCSM_MSI_LINK 16'h9C05
`define BCSM_PD_LINK 16'hA403
`define BCSM_VEND_WORD 32'h0014_C409
`define BCSM_SUB_WORD 32'h0000_E00D
`define BCSM_PCIE_LINK 16'h0010
`define BCSM_EXT_AER_OFF 12'h100
`define BCSM_EXT_VC_OFF 12'h140
`define BCSM_EXT_PB_OFF 12'h20C
`define BCSM_EXT_END 12'h000
`define BCSM_EXT_AER_ID 16'h0001
`define BCSM_EXT_VC_ID 16'h0002
`define BCSM_EXT_PB_ID 16'h0004

// ----------------------------------------------------------------------
// write masks and two-wire slave address
// ----------------------------------------------------------------------
`define BCSM_M_ALL 32'hFFFF_FFFF
`define BCSM_M_NONE 32'h0000_0000
`define BCSM_M_UPPER 32'hFFFF_0000
`define BCSM_M_LOWER 32'h0000_FFFF
`define BCSM_M_NO_INT_PIN 32'hFFFF_00FF
`define BCSM_SMB_ADDR_HI 4'hD
`define BCSM_SMB_LAST_BYTE 3'h7

`endif

/* verilog/bcsm_pkg.sv */
// types shared by the bridge configuration space block
// assumes bcsm_defs.svh carries all numeric constants
package bcsm_pkg;

    // configuration request from the link core
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bcsm_cfg_req_t;

    // per-word attributes: present, and bits each path may write
    typedef struct packed {
        logic impl;
        logic [31:0] cfg_m;
        logic [31:0] smb_m;
    } bcsm_word_attr_t;

    // two-wire slave byte engine
    typedef enum logic [2:0] {
        SMB_IDLE,
        SMB_RX,
        SMB_ACK,
        SMB_TX,
        SMB_TXACK
    } bcsm_smb_state_t;

endpackage

/* verilog/bcsm_top.sv */
// bridge configuration space: type 1 header, capability chain, extended headers
// assumes config requests arrive on clk_sys from the link core, and the
// two-wire bus pins and the mode strap are asynchronous to clk_sys
`timescale 1ns/100ps
`include "bcsm_defs.svh"

// What this block does
// - transparent mode presents one type 1 bridge
// - offset 34h reads 80h
// - product data header id 03 next A4
// - first extended capability at 100h
// - further extended capabilities above 0FFh
// - error, channel, power budget headers linked
// - two-wire slave writes every writable register
// - two-wire bus also presets read-only registers
module bcsm_top #(
    parameter logic [15:0] VENDOR_IDENT = 16'h1A2B, // arbitrary value
    parameter logic [15:0] DEVICE_IDENT = 16'h3C4D, // arbitrary value
    parameter logic [31:0] REV_CLASS = 32'h0000_0000,
    parameter int EXT_CAP_VER = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic transparent_mode,
    input wire bcsm_pkg::bcsm_cfg_req_t cfg_req,
    output logic cfg_rsp_valid,
    output logic [31:0] cfg_rdata,
    input wire logic [2:0] smb_addr_pins,
    input wire logic smb_clk_in,
    output logic smb_clk_out,
    output logic smb_clk_oe,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (EXT_CAP_VER < 0 || EXT_CAP_VER > 15)
    begin : g_bad_ver
        $error("extended capability version must fit four bits");
    end

    // ------------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------------
    logic rst_m; // first reset stage
    logic rst_n; // released reset for the design
    logic mode_s1, mode_s2; // mode strap
    logic scl_s1, scl_s2, scl_s3; // bus clock, third stage for edges
    logic sda_s1, sda_s2, sda_s3; // bus data, third stage for edges
    logic [2:0] pins_s1, pins_s2; // slave address pins

    // two-flop release so the deassertion is clean on clk_sys
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // pins pass two flops, bus clock and data three; edge logic only looks at the later stages
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            pins_s1 <= 3'h0;
            pins_s2 <= 3'h0;
        end
        else
        begin
            mode_s1 <= transparent_mode;
            mode_s2 <= mode_s1;
            scl_s1 <= smb_clk_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= smb_data_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            pins_s1 <= smb_addr_pins;
            pins_s2 <= pins_s1;
        end
    end

    // ------------------------------------------------------------------
    // word attributes and reset values
    // ------------------------------------------------------------------
    // read-only words stay closed to config writes but, apart from chain links, open to the two-wire
    // bus, so a board can preset identity and capability values
    function automatic bcsm_pkg::bcsm_word_attr_t word_attr(input logic [5:0] idx);
        bcsm_pkg::bcsm_word_attr_t a;
        a = '{impl: 1'b1, cfg_m: `BCSM_M_ALL, smb_m: `BCSM_M_ALL};
        unique case ({idx, 2'b00})
            `BCSM_OFF_IDENT, `BCSM_OFF_REV_CLASS, `BCSM_OFF_SUB_IDENT,
            `BCSM_OFF_DEV_CAP, `BCSM_OFF_LINK_CAP, `BCSM_OFF_SLOT_CAP:
                a.cfg_m = `BCSM_M_NONE;
            `BCSM_OFF_LINE_HDR:
            begin
                a.cfg_m = `BCSM_M_LOWER; // header type byte is fixed
                a.smb_m = `BCSM_M_LOWER;
            end
            `BCSM_OFF_CAP_PTR, `BCSM_OFF_VEND_HDR, `BCSM_OFF_SUB_HDR:
            begin
                a.cfg_m = `BCSM_M_NONE; // chain links never move
                a.smb_m = `BCSM_M_NONE;
            end
            `BCSM_OFF_INT_BRIDGE:
                a.cfg_m = `BCSM_M_NO_INT_PIN; // interrupt pin read-only
            `BCSM_OFF_PM_HDR, `BCSM_OFF_PCIE_HDR:
            begin
                a.cfg_m = `BCSM_M_NONE;
                a.smb_m = `BCSM_M_UPPER;
            end
            `BCSM_OFF_MSI_HDR, `BCSM_OFF_PD_HDR:
            begin
                a.cfg_m = `BCSM_M_UPPER; // control half writable
                a.smb_m = `BCSM_M_UPPER;
            end
            `BCSM_OFF_CMD_STAT, `BCSM_OFF_BUS_NUM, `BCSM_OFF_IO_WIN,
            `BCSM_OFF_MEM_WIN, `BCSM_OFF_PF_WIN, `BCSM_OFF_PF_BASE_UP,
            `BCSM_OFF_PF_LIM_UP, `BCSM_OFF_IO_UP, `BCSM_OFF_PM_DATA,
            `BCSM_OFF_MSI_ADDR, `BCSM_OFF_MSI_UADDR, `BCSM_OFF_MSI_DATA,
            `BCSM_OFF_PD_WORD, `BCSM_OFF_CSR_A, `BCSM_OFF_CSR_B,
            `BCSM_OFF_ACK_REPLAY, `BCSM_OFF_PHY_CTL0, `BCSM_OFF_CSR_C,
            `BCSM_OFF_PHY_CTL2, `BCSM_OFF_LANE, `BCSM_OFF_PIN_IO,
            `BCSM_OFF_PROM, `BCSM_OFF_DEV_CTL, `BCSM_OFF_LINK_CTL,
            `BCSM_OFF_SLOT_CTL:
                a.impl = 1'b1; // both paths write everything
            default:
                a = '{impl: 1'b0, cfg_m: `BCSM_M_NONE, smb_m: `BCSM_M_NONE};
        endcase
        return a;
    endfunction

    // reset contents; chain headers carry their id and next pointer
    function automatic logic [31:0] rst_val(input logic [5:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case ({idx, 2'b00})
            `BCSM_OFF_IDENT: v = {DEVICE_IDENT, VENDOR_IDENT};
            `BCSM_OFF_REV_CLASS: v = REV_CLASS;
            `BCSM_OFF_LINE_HDR: v = {8'h00, `BCSM_HDR_TYPE_BRIDGE, 16'h0000};
            `BCSM_OFF_CAP_PTR: v = {24'h00_0000, `BCSM_CAP_PTR_FIRST};
            `BCSM_OFF_PM_HDR: v = {16'h0000, `BCSM_PM_LINK};
            `BCSM_OFF_MSI_HDR: v = {16'h0000, `BCSM_MSI_LINK};
            `BCSM_OFF_PD_HDR: v = {16'h0000, `BCSM_PD_LINK};
            `BCSM_OFF_VEND_HDR: v = `BCSM_VEND_WORD;
            `BCSM_OFF_SUB_HDR: v = `BCSM_SUB_WORD;
            `BCSM_OFF_PCIE_HDR: v = {16'h0000, `BCSM_PCIE_LINK};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // storage of the standard header region
    // ------------------------------------------------------------------
    logic [31:0] mem [64]; // one word per dword of 00h to FFh
    logic [31:0] smb_word; // assembled two-wire write data
    logic [11:0] smb_off; // two-wire register pointer
    logic smb_commit; // one-cycle write strobe from the slave
    logic cfg_wr_hit; // config write into the standard region
    logic [31:0] cfg_be_m; // byte enables widened to bits

    assign cfg_wr_hit = cfg_req.valid && cfg_req.write && mode_s2 &&
                        (cfg_req.addr[11:8] == 4'h0);
    assign cfg_be_m = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}},
                       {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};

    // one process per word; a two-wire write in the same cycle wins
    for (genvar i = 0; i < 64; i++)
    begin : g_word
        logic [31:0] cm; // config mask for this word
        logic [31:0] sm; // two-wire mask for this word
        bcsm_pkg::bcsm_word_attr_t wa; // attributes of this word
        assign wa = word_attr(6'(i));
        assign cm = wa.cfg_m & cfg_be_m;
        assign sm = wa.smb_m;
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
                mem[i] <= rst_val(6'(i));
            else if (smb_commit && smb_off[11:8] == 4'h0 && smb_off[7:2] == 6'(i))
                mem[i] <= (mem[i] & ~sm) | (smb_word & sm);
            else if (cfg_wr_hit && cfg_req.addr[7:2] == 6'(i))
                mem[i] <= (mem[i] & ~cm) | (cfg_req.wdata & cm);
        end
    end

    // ------------------------------------------------------------------
    // read decode, shared by both access paths
    // ------------------------------------------------------------------
    // extended headers are constants; their bodies read zero here
    function automatic logic [31:0] read_at(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[11:8] == 4'h0)
        begin
            if (word_attr(a[7:2]) != '0) // implemented words carry a set flag
                v = mem[a[7:2]];
        end
        else
        begin
            unique case ({a[11:2], 2'b00})
                `BCSM_EXT_AER_OFF: v = {`BCSM_EXT_VC_OFF, 4'(EXT_CAP_VER),
                                        `BCSM_EXT_AER_ID};
                `BCSM_EXT_VC_OFF: v = {`BCSM_EXT_PB_OFF, 4'(EXT_CAP_VER),
                                       `BCSM_EXT_VC_ID};
                `BCSM_EXT_PB_OFF: v = {`BCSM_EXT_END, 4'(EXT_CAP_VER),
                                       `BCSM_EXT_PB_ID};
                default: v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // configuration response
    // ------------------------------------------------------------------
    // every request answered one cycle later; outside transparent mode
    // the bridge view is hidden and reads return zero
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rsp_valid <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end
        else
        begin
            cfg_rsp_valid <= cfg_req.valid;
            if (cfg_req.valid && !cfg_req.write && mode_s2)
                cfg_rdata <= read_at(cfg_req.addr);
            else
                cfg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // two-wire slave
    // ------------------------------------------------------------------
    bcsm_pkg::bcsm_smb_state_t smb_state; // byte engine state
    logic scl_rise, scl_fall, bus_start, bus_stop; // bus events
    logic [3:0] bit_cnt; // bits moved in current byte
    logic [7:0] rx_sh; // receive shifter
    logic [7:0] tx_sh; // transmit shifter
    logic [2:0] byte_idx; // byte position since start
    logic [1:0] tx_idx; // read byte, low byte first
    logic rd_mode; // direction bit of address byte
    logic [31:0] rd_word; // word captured for a read
    logic [31:0] smb_rd; // live read of the pointer

    assign scl_rise = scl_s2 && !scl_s3;
    assign scl_fall = !scl_s2 && scl_s3;
    assign bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign bus_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
    assign smb_rd = read_at(smb_off);

    // slave never drives the clock and only pulls data low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            smb_clk_out <= 1'b0;
            smb_clk_oe <= 1'b0;
            smb_data_out <= 1'b0;
        end
        else
        begin
            smb_clk_out <= 1'b0;
            smb_clk_oe <= 1'b0;
            smb_data_out <= 1'b0;
        end
    end

    // frame: address, pointer high, pointer low, four data bytes low first;
    // a read re-addresses after a repeated start and streams the word
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            smb_state <= bcsm_pkg::SMB_IDLE;
            bit_cnt <= 4'h0;
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            byte_idx <= 3'h0;
            tx_idx <= 2'h0;
            rd_mode <= 1'b0;
            rd_word <= 32'h0000_0000;
            smb_off <= 12'h000;
            smb_word <= 32'h0000_0000;
            smb_commit <= 1'b0;
            smb_data_oe <= 1'b0;
        end
        else
        begin
            // commit only a complete write frame, at its stop
            smb_commit <= bus_stop && !rd_mode && byte_idx == `BCSM_SMB_LAST_BYTE &&
                          smb_state != bcsm_pkg::SMB_IDLE;
            if (bus_start)
            begin
                // start and repeated start both restart the address phase
                smb_state <= bcsm_pkg::SMB_RX;
                bit_cnt <= 4'h0;
                byte_idx <= 3'h0;
                smb_data_oe <= 1'b0;
            end
            else if (bus_stop)
            begin
                smb_state <= bcsm_pkg::SMB_IDLE;
                smb_data_oe <= 1'b0;
            end
            else
            begin
                unique case (smb_state)
                    bcsm_pkg::SMB_IDLE:
                        smb_data_oe <= 1'b0;
                    bcsm_pkg::SMB_RX:
                    begin
                        if (scl_rise && bit_cnt < 4'h8)
                        begin
                            rx_sh <= {rx_sh[6:0], sda_s2};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall && bit_cnt == 4'h8)
                        begin
                            bit_cnt <= 4'h0;
                            byte_idx <= byte_idx + 3'h1;
                            smb_state <= bcsm_pkg::SMB_ACK;
                            smb_data_oe <= 1'b1; // ack by pulling low
                            unique case (byte_idx)
                                3'h0:
                                begin
                                    // other addresses: let go of the bus
                                    if (rx_sh[7:1] == {`BCSM_SMB_ADDR_HI, pins_s2})
                                        rd_mode <= rx_sh[0];
                                    else
                                    begin
                                        smb_state <= bcsm_pkg::SMB_IDLE;
                                        smb_data_oe <= 1'b0;
                                    end
                                end
                                3'h1: smb_off[11:8] <= rx_sh[3:0];
                                3'h2: smb_off[7:0] <= {rx_sh[7:2], 2'b00};
                                3'h3: smb_word[7:0] <= rx_sh;
                                3'h4: smb_word[15:8] <= rx_sh;
                                3'h5: smb_word[23:16] <= rx_sh;
                                3'h6: smb_word[31:24] <= rx_sh;
                                default:
                                begin
                                    // excess byte is refused with a nack
                                    byte_idx <= byte_idx;
                                    smb_state <= bcsm_pkg::SMB_IDLE;
                                    smb_data_oe <= 1'b0;
                                end
                            endcase
                        end
                    end
                    bcsm_pkg::SMB_ACK:
                    begin
                        if (scl_fall && rd_mode && byte_idx == 3'h1)
                        begin
                            // capture once so all four bytes are coherent
                            rd_word <= smb_rd;
                            tx_idx <= 2'h0;
                            smb_data_oe <= !smb_rd[7];
                            tx_sh <= {smb_rd[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                            smb_state <= bcsm_pkg::SMB_TX;
                        end
                        else if (scl_fall)
                        begin
                            smb_data_oe <= 1'b0;
                            smb_state <= bcsm_pkg::SMB_RX;
                        end
                    end
                    bcsm_pkg::SMB_TX:
                    begin
                        if (scl_fall && bit_cnt < 4'h8)
                        begin
                            smb_data_oe <= !tx_sh[7];
                            tx_sh <= {tx_sh[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            smb_data_oe <= 1'b0;
                            smb_state <= bcsm_pkg::SMB_TXACK;
                        end
                    end
                    bcsm_pkg::SMB_TXACK:
                    begin
                        if (scl_rise && sda_s2)
                            smb_state <= bcsm_pkg::SMB_IDLE; // master nack ends
                        else if (scl_rise)
                        begin
                            tx_idx <= tx_idx + 2'h1;
                            tx_sh <= rd_word[{tx_idx + 2'h1, 3'b000} +: 8];
                            bit_cnt <= 4'h0;
                            smb_state <= bcsm_pkg::SMB_TX;
                        end
                    end
                endcase
            end
        end
    end

endmodule

/* verif/bcsm_properties.sv */
// assertions on the config port of the bridge configuration space
// assumes it is bound into bcsm_top and sees only its ports
`timescale 1ns/100ps
module bcsm_properties (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic transparent_mode,
    input wire bcsm_pkg::bcsm_cfg_req_t cfg_req,
    input wire logic cfg_rsp_valid,
    input wire logic [31:0] cfg_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // read of word a while the synced mode is m answers masked value v next cycle
    property rd_p(a, m, k, v);
        cfg_req.valid && !cfg_req.write && cfg_req.addr[11:2] == a &&
        $past(transparent_mode, 2) == m |=> (cfg_rdata & k) == v;
    endproperty
    rsp_next_a: assert property (cfg_req.valid |=> cfg_rsp_valid) else $error("no answer");
    rsp_once_a: assert property (cfg_rsp_valid |-> $past(cfg_req.valid)) else $error("stray");
    cap_ptr_a: assert property (rd_p(10'h00D, 1'h1, 32'hFF, 32'h80)) else $error("pointer");
    pd_link_a: assert property (rd_p(10'h027, 1'h1, 32'hFFFF, 32'hA403)) else $error("pd");
    pm_link_a: assert property (rd_p(10'h020, 1'h1, 32'hFFFF, 32'h8C01)) else $error("pm");
    ext_first_a: assert property (rd_p(10'h040, 1'h1, 32'hFFF0_FFFF, 32'h1400_0001))
        else $error("first extended");
    // any extended read: a next pointer is either zero or beyond the header region
    ext_above_a: assert property (cfg_req.valid && cfg_req.addr[11:8] != 4'h0
        ##1 cfg_rsp_valid |-> cfg_rdata[31:20] == 12'h0 || cfg_rdata[31:20] > 12'h0FF)
        else $error("next");
    mode_low_a: assert property (cfg_req.valid && !$past(transparent_mode, 2)
        |=> cfg_rdata == 32'h0) else $error("hidden view");
    cover property (cfg_req.valid && cfg_req.write ##1 cfg_rsp_valid);
    cover property (cfg_req.valid && !transparent_mode);
    cover property (cfg_rsp_valid && cfg_rdata == 32'h80);
endmodule
bind bcsm_top bcsm_properties u_props (.clk_sys(clk_sys), .nrst(nrst),
    .transparent_mode(transparent_mode), .cfg_req(cfg_req), .cfg_rsp_valid(cfg_rsp_valid),
    .cfg_rdata(cfg_rdata));

/* verif/bcsm_root_model.sv */
// root complex model: one config request at a time
// assumes answers are registered on the taking edge itself and read just after it
`timescale 1ns/100ps
module bcsm_root_model (
    input wire logic clk_sys,
    input wire logic cfg_rsp_valid,
    input wire logic [31:0] cfg_rdata,
    output bcsm_pkg::bcsm_cfg_req_t cfg_req
);
    // idle request, junk in the qualifying fields
    initial cfg_req = '{valid: 1'h0, write: 1'h0, addr: 12'hFFF, be: 4'h0, wdata: 32'h5A5A_5A5A};
    // drive after an edge, hold through the taking edge, sample the answer
    task automatic request(input logic wr, input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] rdata);
        @(posedge clk_sys);
        #1;
        cfg_req = '{valid: 1'h1, write: wr, addr: a, be: be, wdata: d};
        @(posedge clk_sys);
        #1;
        // inverse on released fields so a stale value never passes
        cfg_req = '{valid: 1'h0, write: ~wr, addr: ~a, be: ~be, wdata: ~d};
        rdata = cfg_rsp_valid ? cfg_rdata : 32'hDEAD_BEEF;
    endtask
endmodule

/* verif/testbench.sv */
// self-checking bench for the bridge configuration space
// assumes the root model issues requests and the two-wire bus idles high
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic transparent_mode = 1'h1;
    bcsm_pkg::bcsm_cfg_req_t cfg_req;
    logic cfg_rsp_valid;
    logic [31:0] cfg_rdata;
    logic [31:0] rd;
    logic scl = 1'h1;
    logic sda = 1'h1;
    logic sda_oe;
    int fail_count = 0;
    int checks_done = 0;
    always #20 clk_sys = ~clk_sys;
    bcsm_top dut (.clk_sys(clk_sys), .nrst(nrst), .transparent_mode(transparent_mode),
        .cfg_req(cfg_req), .cfg_rsp_valid(cfg_rsp_valid), .cfg_rdata(cfg_rdata),
        .smb_addr_pins(3'h5), .smb_clk_in(scl), .smb_clk_out(), .smb_clk_oe(),
        .smb_data_in(sda & !sda_oe), .smb_data_out(), .smb_data_oe(sda_oe));
    bcsm_root_model root (.clk_sys(clk_sys), .cfg_rsp_valid(cfg_rsp_valid),
        .cfg_rdata(cfg_rdata), .cfg_req(cfg_req));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        root.request(1'h0, a, 4'hF, 32'h0, rd);
        check(what, rd, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        root.request(1'h1, a, be, d, rd);
    endtask
    // two-wire master levels, each held six clocks
    task automatic tw_lv(input logic c, input logic d);
        scl = c;
        sda = d;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    // frame: start, address, pointer, data low byte first, ack each byte, stop
    task automatic tw_write(input logic [11:0] a, input logic [31:0] d);
        logic [55:0] f;
        f = {8'hDA, 4'h0, a, d[7:0], d[15:8], d[23:16], d[31:24]};
        tw_lv(1'h1, 1'h0);
        for (int n = 55; n >= 0; n--)
        begin
            tw_lv(1'h0, f[n]);
            tw_lv(1'h1, f[n]);
            if (n % 8 == 0)
            begin
                tw_lv(1'h0, 1'h1);
                tw_lv(1'h1, 1'h1);
                check("two-wire ack", {31'h0, sda_oe}, 32'h1);
            end
        end
        tw_lv(1'h0, 1'h0);
        tw_lv(1'h1, 1'h0);
        tw_lv(1'h1, 1'h1);
        rd_chk("two-wire word", a, d);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset words of both capability chains, offset then value
    task automatic t_chain;
        logic [43:0] tbl [12] = '{44'h000_3C4D1A2B, 44'h00C_00010000, 44'h034_00000080,
            44'h080_00008C01, 44'h08C_00009C05, 44'h09C_0000A403, 44'h0A4_0014C409,
            44'h0C4_0000E00D, 44'h0E0_00000010, 44'h100_14010001, 44'h140_20C10002,
            44'h20C_00010004};
        foreach (tbl[i])
            rd_chk("chain word", tbl[i][43:32], tbl[i][31:0]);
    endtask
    // writable, masked and fixed words, then a dropped extended write
    task automatic t_write;
        wr(12'h018, 4'hF, 32'hFFFF_FFFF);
        rd_chk("bus numbers", 12'h018, 32'hFFFF_FFFF);
        wr(12'h03C, 4'hF, 32'hFFFF_FFFF);
        rd_chk("bridge control", 12'h03C, 32'hFFFF_00FF);
        wr(12'h028, 4'h1, 32'h1234_5678);
        rd_chk("byte enable", 12'h028, 32'h0000_0078);
        wr(12'h034, 4'hF, 32'h0);
        rd_chk("chain pointer", 12'h034, 32'h0000_0080);
        wr(12'h100, 4'hF, 32'h0);
        rd_chk("extended header", 12'h100, 32'h1401_0001);
    endtask
    // bridge view withdrawn: reads give zero, writes dropped
    task automatic t_mode;
        transparent_mode = 1'h0;
        repeat (6) @(posedge clk_sys);
        rd_chk("hidden pointer", 12'h034, 32'h0);
        wr(12'h018, 4'hF, 32'h0);
        transparent_mode = 1'h1;
        repeat (6) @(posedge clk_sys);
        rd_chk("kept bus numbers", 12'h018, 32'hFFFF_FFFF);
    endtask
    // a writable word, then a read-only word preset over the two-wire bus
    task automatic t_twowire;
        tw_write(12'h018, 32'h1122_3344);
        tw_write(12'h000, 32'h5566_7788);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1;
        nrst = 1'h1;
        repeat (6) @(posedge clk_sys);
        t_chain;
        t_write;
        t_mode;
        t_twowire;
        conclude;
    end
    // watchdog: two-wire frames need ~1600 cycles, this allows 5000
    initial
    begin
        #200000;
        fail_count++;
        conclude;
    end
endmodule
